// [design/rfp_defines.svh]
`ifndef RFP_DEFINES_SVH
`define RFP_DEFINES_SVH

// Reset vector location and status bit position
`define RFP_RESET_VECTOR 24'hFF_FF00
`define RFP_PC_RESET 24'h00_0000
`define RFP_ST1_FLAG_BIT 4'hD
`define RFP_ST1_RESET 16'h0000
`define RFP_BOOT_ADDR_RESET 24'h00_0000

`endif

// [design/rfp_pkg.sv]
package rfp_pkg;

   // Core sequencing states, one-hot
   typedef enum logic [3:0] {
      RFP_IN_RESET = 4'b0001,
      RFP_FETCH_VEC = 4'b0010,
      RFP_WAIT_VEC = 4'b0100,
      RFP_RUN = 4'b1000
   } rfp_state_t;

endpackage : rfp_pkg

// [design/rfp_pin_ctl.sv]
`timescale 1ns/1ps
`include "rfp_defines.svh"

module rfp_pin_ctl (
   input wire logic clk, // Core clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic scan_mode, // Boundary-scan mode active
   input wire logic scan_hiz, // Scan request to float pin
   input wire logic flag_val, // Internal flag value
   output logic pin_out, // Pin output level
   output logic pin_oe, // Pin output enable
   output logic pullup_en // Internal pull-up enable
);

   logic hiz_d, hiz_q;
   logic out_d, out_q;

   always_comb begin
      hiz_d = scan_mode & scan_hiz; // [RQ3]
      out_d = flag_val;
      if (!resetn) begin
         hiz_d = 1'b0;
         out_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      hiz_q <= hiz_d;
      out_q <= out_d;
   end

   assign pin_out = out_q;
   assign pin_oe = ~hiz_q; // [RQ3]
   // Pull-up off in reset even if floating
   assign pullup_en = hiz_q & resetn; // [RQ4] [RQ5]

   AST_HIZ_ONLY_SCAN: assert property (@(posedge clk) // [RQ3]
      disable iff (!resetn) !pin_oe |-> $past(scan_mode))
      else $error("Pin floated outside scan mode");
   AST_PU_WHEN_HIZ: assert property (@(posedge clk) // [RQ4]
      disable iff (!resetn) (pin_oe == 1'b0) |-> pullup_en)
      else $error("Pull-up off while pin floats");
   AST_PU_OFF_RESET: assert property (@(posedge clk) // [RQ5]
      !resetn |-> (!pullup_en ##1 (!pullup_en && pin_oe)))
      else $error("Pull-up on or pin floating in reset");

endmodule : rfp_pin_ctl

// [design/rfp_flag_reset.sv]
`timescale 1ns/1ps
`include "rfp_defines.svh"

// Operation
// [RQ1] The flag set instruction drives the external flag output high.
// [RQ2] The flag clear instruction or writing one to status bit 13 drives it low.
// [RQ3] The flag pin may float only in boundary-scan mode, else it is driven.
// [RQ4] While the flag pin floats its internal pull-up is enabled.
// [RQ5] The internal pull-up stays disabled while reset is in effect.
// [RQ6] Reset stops execution, loads the PC from the vector, resets status.
// [RQ7] On release the vector at FFFF00h is fetched and boot ROM is entered.
// [RQ8] Other processors may sample the flag as a signalling or GPIO line.
// [RQ9] The reset source holds reset low and drives it high to release.
module rfp_flag_reset (
   input wire logic clk, // Core clock, 25 MHz
   input wire logic resetn, // Device reset, active low
   input wire logic flag_set_instruction, // Set-flag instruction executes
   input wire logic flag_clear_instruction, // Clear-flag instruction executes
   input wire logic st1_wr, // Write strobe, status register one
   input wire logic [15:0] st1_wdata, // Write data, status register one
   input wire logic scan_mode, // Boundary-scan mode active
   input wire logic scan_hiz, // Scan request to float flag pin
   input wire logic vec_rvalid, // ROM read data valid
   input wire logic [23:0] vec_rdata, // ROM read data: boot address
   output logic vec_req, // ROM read request, one cycle
   output logic [23:0] vec_addr, // ROM read address
   output logic [23:0] pc, // Program counter
   output logic run, // Program execution enabled
   output logic boot_branch, // Branch into boot loader, one cycle
   output logic [15:0] cpu_status_register_one, // Status register one
   output logic external_flag_output, // Flag pin output level
   output logic external_flag_oe, // Flag pin output enable
   output logic internal_pullup // Flag pin pull-up enable
);

   ////////////////////////////////////////////////////////////////////////
   rfp_pkg::rfp_state_t state_d, state_q;
   logic [23:0] pc_d, pc_q;
   logic [15:0] st1_d, st1_q;
   logic vreq_d, vreq_q;
   logic br_d, br_q;

   always_comb begin
      state_d = state_q;
      pc_d = pc_q;
      vreq_d = 1'b0;
      br_d = 1'b0;
      case (state_q)
         rfp_pkg::RFP_IN_RESET: begin
            state_d = rfp_pkg::RFP_FETCH_VEC; // [RQ7]
         end
         rfp_pkg::RFP_FETCH_VEC: begin
            vreq_d = 1'b1; // [RQ7]
            state_d = rfp_pkg::RFP_WAIT_VEC;
         end
         rfp_pkg::RFP_WAIT_VEC: begin
            if (vec_rvalid) begin
               pc_d = vec_rdata; // [RQ7]
               br_d = 1'b1;
               state_d = rfp_pkg::RFP_RUN;
            end
         end
         rfp_pkg::RFP_RUN: begin
            state_d = rfp_pkg::RFP_RUN;
         end
         default: begin
            state_d = rfp_pkg::RFP_IN_RESET;
         end
      endcase
      if (!resetn) begin
         // Execution halts and PC holds the vector until release
         state_d = rfp_pkg::RFP_IN_RESET; // [RQ6]
         pc_d = `RFP_RESET_VECTOR; // [RQ6]
         vreq_d = 1'b0;
         br_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      state_q <= state_d;
      pc_q <= pc_d;
      vreq_q <= vreq_d;
      br_q <= br_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag bit lives in status register one; clear wins a same-cycle set
   // since a status write carries explicit software intent
   always_comb begin
      st1_d = st1_q;
      if (st1_wr) begin
         st1_d = st1_wdata;
      end
      if (flag_set_instruction) begin
         st1_d[`RFP_ST1_FLAG_BIT] = 1'b1; // [RQ1]
      end
      if (flag_clear_instruction) begin
         st1_d[`RFP_ST1_FLAG_BIT] = 1'b0; // [RQ2]
      end
      if (st1_wr && st1_wdata[`RFP_ST1_FLAG_BIT]) begin
         st1_d[`RFP_ST1_FLAG_BIT] = 1'b0; // [RQ2]
      end
      if (!resetn) begin
         st1_d = `RFP_ST1_RESET; // [RQ6]
      end
   end

   always_ff @(posedge clk) begin
      st1_q <= st1_d;
   end

   rfp_pin_ctl u_pin (
      .clk(clk),
      .resetn(resetn),
      .scan_mode(scan_mode),
      .scan_hiz(scan_hiz),
      .flag_val(st1_d[`RFP_ST1_FLAG_BIT]),
      .pin_out(external_flag_output),
      .pin_oe(external_flag_oe),
      .pullup_en(internal_pullup)
   );

   assign vec_req = vreq_q;
   assign vec_addr = `RFP_RESET_VECTOR;
   assign pc = pc_q;
   assign run = (state_q == rfp_pkg::RFP_RUN);
   assign boot_branch = br_q;
   assign cpu_status_register_one = st1_q;

   ////////////////////////////////////////////////////////////////////////
   // Flag bit and pin
   AST_SET_HIGH: assert property (@(posedge clk) // [RQ1]
      disable iff (!resetn)
      (flag_set_instruction && !flag_clear_instruction && !st1_wr)
      |=> external_flag_output)
      else $error("Flag not high after set");

   AST_CLR_LOW: assert property (@(posedge clk) // [RQ2]
      disable iff (!resetn)
      flag_clear_instruction |=> !external_flag_output)
      else $error("Flag not low after clear");

   AST_WR_LOW: assert property (@(posedge clk) // [RQ2]
      disable iff (!resetn)
      (st1_wr && st1_wdata[`RFP_ST1_FLAG_BIT]) |=> !external_flag_output)
      else $error("Flag not low after status write");

   AST_PIN_MIRRORS: assert property (@(posedge clk) // [RQ1] [RQ2]
      disable iff (!resetn)
      external_flag_output == cpu_status_register_one[`RFP_ST1_FLAG_BIT])
      else $error("Flag pin differs from status bit");

   // Pin moves only on a command; catches a stray update path
   AST_FLAG_HOLDS: assert property (@(posedge clk) // [RQ1] [RQ2]
      disable iff (!resetn)
      (!flag_set_instruction && !flag_clear_instruction && !st1_wr)
      |=> $stable(external_flag_output))
      else $error("Flag moved without a command");

   AST_DRIVEN_OUTSIDE_SCAN: assert property (@(posedge clk) // [RQ3]
      disable iff (!resetn) !scan_mode |=> external_flag_oe)
      else $error("Flag pin floats outside scan");

   ////////////////////////////////////////////////////////////////////////
   // Reset and boot sequence
   AST_RESET_HALT: assert property (@(posedge clk) // [RQ6]
      !resetn |=> (!run && pc == `RFP_RESET_VECTOR))
      else $error("Not halted with vector in reset");

   AST_RESET_ST1: assert property (@(posedge clk) // [RQ6]
      !resetn |=> cpu_status_register_one == `RFP_ST1_RESET)
      else $error("Status not reset");

   AST_RESET_PIN: assert property (@(posedge clk) // [RQ6]
      !resetn |=> (!external_flag_output && external_flag_oe))
      else $error("Flag pin not low and driven in reset");

   AST_PC_VECTOR: assert property (@(posedge clk) // [RQ6]
      disable iff (!resetn) !run |-> pc == `RFP_RESET_VECTOR)
      else $error("Program counter left vector before branch");

   AST_STATE_ONEHOT: assert property (@(posedge clk) // [RQ6]
      disable iff (!resetn) $onehot(state_q))
      else $error("Sequencer state not one-hot");

   // Request shows one edge after the second edge that sees release
   AST_VEC_FETCH: assert property (@(posedge clk) // [RQ7]
      (!resetn ##1 resetn [*2])
      |=> (vec_req && vec_addr == `RFP_RESET_VECTOR))
      else $error("Vector not fetched after release");

   AST_REQ_PULSE: assert property (@(posedge clk) // [RQ7]
      disable iff (!resetn) vec_req |=> !vec_req)
      else $error("Vector request longer than one cycle");

   // Data arriving outside the wait state is ignored by design
   AST_WAIT_HOLDS: assert property (@(posedge clk) // [RQ7]
      disable iff (!resetn)
      (state_q == rfp_pkg::RFP_WAIT_VEC && !vec_rvalid)
      |=> (!run && !boot_branch))
      else $error("Left wait state without vector data");

   AST_BOOT_BRANCH: assert property (@(posedge clk) // [RQ7]
      disable iff (!resetn)
      (state_q == rfp_pkg::RFP_WAIT_VEC && vec_rvalid)
      |=> (boot_branch && run && pc == $past(vec_rdata)))
      else $error("No branch to boot loader");

   AST_RUN_AFTER_BRANCH: assert property (@(posedge clk) // [RQ7]
      disable iff (!resetn) $rose(run) |-> boot_branch)
      else $error("Execution started without boot branch");

   AST_RUN_HOLDS: assert property (@(posedge clk) // [RQ7]
      disable iff (!resetn) run |=> (run && $stable(pc)))
      else $error("Execution or program counter disturbed");

   ////////////////////////////////////////////////////////////////////////
   COV_SET: cover property (@(posedge clk) flag_set_instruction
      ##1 external_flag_output);
   COV_WR_CLR: cover property (@(posedge clk) st1_wr ##1 !external_flag_output);
   COV_SET_WR_CLR: cover property (@(posedge clk)
      flag_set_instruction && st1_wr ##1 !external_flag_output);
   COV_BOOT: cover property (@(posedge clk) boot_branch);
   COV_HIZ: cover property (@(posedge clk) internal_pullup);

endmodule : rfp_flag_reset

// [sim/rfp_rom_model.sv]
`timescale 1ns/1ps
module rfp_rom_model #(parameter logic [23:0] BOOT = 24'h00_4A50) (
   input wire logic clk, // Core clock
   input wire logic resetn, // Reset, active low
   input wire logic [3:0] lat, // Answer delay, 1 or more cycles
   input wire logic vec_req, // Read request
   output logic vec_rvalid, // Read data valid
   output logic [23:0] vec_rdata // Read data
);
   logic [3:0] cnt_q;
   always_ff @(posedge clk) begin
      if (!resetn) cnt_q <= 4'h0;
      else if (vec_req) cnt_q <= lat;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   end
   assign vec_rvalid = (cnt_q == 4'h1);
   // Inverse when idle so stale data never matches
   assign vec_rdata = vec_rvalid ? BOOT : ~BOOT;
endmodule : rfp_rom_model

// [sim/reset_and_flag_output_pin_tb.sv]
`timescale 1ns/1ps
`include "rfp_defines.svh"
module reset_and_flag_output_pin_tb;
   localparam logic [23:0] BOOT = 24'h00_4A50;
   logic clk = 0, resetn = 0, fset = 0, fclr = 0, st1_wr = 0;
   logic [15:0] st1_wdata = 16'h0000;
   logic scan_mode = 0, scan_hiz = 0, vec_rvalid, vec_req, run;
   logic [23:0] vec_rdata, vec_addr, pc;
   logic boot_branch, flag, oe, pu;
   logic [15:0] st1;
   logic [3:0] lat = 4'h1;
   int failures = 0, checks = 0, cyc = 0;
   rfp_flag_reset u_dut (.clk, .resetn, .flag_set_instruction(fset),
      .flag_clear_instruction(fclr), .st1_wr, .st1_wdata, .scan_mode,
      .scan_hiz, .vec_rvalid, .vec_rdata, .vec_req, .vec_addr, .pc, .run,
      .boot_branch, .cpu_status_register_one(st1),
      .external_flag_output(flag), .external_flag_oe(oe),
      .internal_pullup(pu));
   rfp_rom_model #(.BOOT(BOOT)) u_rom (.clk, .resetn, .lat, .vec_req,
      .vec_rvalid, .vec_rdata);
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic t_boot(input logic [3:0] l);
      int n;
      @(posedge clk) resetn <= 1'b0;
      lat <= l;
      repeat (2) @(posedge clk);
      #1 chk(run, 0);
      chk(pc, `RFP_RESET_VECTOR);
      chk(st1, 0);
      chk(pu, 0);
      @(posedge clk) resetn <= 1'b1;
      n = 0;
      while (boot_branch !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
         if (vec_req === 1'b1) begin
            chk(vec_addr, `RFP_RESET_VECTOR);
            chk(24'(n), 24'h00_0002);
         end
      end
      chk(24'(n), 24'(3 + l));
      chk(pc, BOOT);
      chk(run, 1);
      @(posedge clk);
      #1 chk(boot_branch, 0);
      chk(pc, BOOT);
   endtask : t_boot
   task automatic t_flag;
      @(posedge clk) fset <= 1'b1;
      @(posedge clk) fset <= 1'b0;
      fclr <= 1'b1;
      #1 chk(flag, 1);
      chk(oe, 1);
      @(posedge clk) fclr <= 1'b0;
      fset <= 1'b1;
      st1_wr <= 1'b1;
      st1_wdata <= 16'h2000;
      #1 chk(flag, 0);
      @(posedge clk) st1_wr <= 1'b0;
      #1 chk(flag, 0);
      @(posedge clk) fset <= 1'b0;
      st1_wr <= 1'b1;
      #1 chk(flag, 1);
      @(posedge clk) st1_wr <= 1'b0;
      #1 chk(flag, 0);
      chk(st1, 16'h0000);
      @(posedge clk) fset <= 1'b1;
      st1_wr <= 1'b1;
      st1_wdata <= 16'h1234;
      @(posedge clk) fset <= 1'b0;
      st1_wr <= 1'b0;
      #1 chk(st1, 16'h3234);
      chk(flag, 1);
   endtask : t_flag
   task automatic t_scan;
      // Float request alone must not release the pin
      @(posedge clk) scan_hiz <= 1'b1;
      @(posedge clk) scan_mode <= 1'b1;
      #1 chk(oe, 1);
      chk(pu, 0);
      @(posedge clk);
      #1 chk(oe, 0);
      chk(pu, 1);
      @(posedge clk) resetn <= 1'b0;
      #1 chk(pu, 0);
      @(posedge clk) scan_mode <= 1'b0;
      scan_hiz <= 1'b0;
   endtask : t_scan
   initial begin
      t_boot(4'h1);
      t_flag();
      t_scan();
      t_boot(4'h4);
      t_flag();
      test_done();
   end
endmodule : reset_and_flag_output_pin_tb
